// ==== rtl/smr_cfg.svh ====
// Purpose : Constants of the stop-mode and reset sequencer
// Assumes : sys_clk at 40 MHz
// Notes   : Offsets are byte addresses on the plain register port
//
// How it works
// - Stop entered only from main system clock
// - Pending unmasked interrupt cancels stop into halt
// - Unmasked interrupt releases stop after settling
// - Post-release wait nine or three clocks
// - Fast oscillator accuracy wait after release
// - Mask, priority, enable, in-service pick action
// - Reset releases stop, branches to vector
// - Four reset sources feed internal reset
// - All sources equal; start at vector 0000H
// - Pins float during reset and settling
// - Pin reset held low, resumes on fast oscillator
// - Watchdog reset self-releases, fast oscillator start
// - Detector resets release when supply recovers
// - Reset stops every oscillator, ignores clock input
// - Reset from stop keeps contents while the source stands, floats pins
// - Low-supply reset spares the low-supply logic
// - Watchdog runs in stop unless stoppable
// - Slow oscillator keeps pre-stop state in stop
// - Counter and display run on subclock only
// - Serial runs only on running counter output
`ifndef SMR_CFG_SVH
`define SMR_CFG_SVH

`define SMR_ADDR_CTRL      4'h0
`define SMR_ADDR_STATUS    4'h4
`define SMR_ADDR_CAUSE     4'h8

`define SMR_CTRL_SW_STOP   0
`define SMR_CTRL_SLOW_RUN  1
`define SMR_CTRL_RTC_SUB   2
`define SMR_CTRL_LCD_SUB   3
`define SMR_CTRL_SER_CNT   4
`define SMR_CTRL_CNT_RUN   5
`define SMR_CTRL_SUB_RUN   6
`define SMR_CTRL_LSD_EN    7
`define SMR_CTRL_SEL_LO    8
`define SMR_CTRL_RESET     16'h0042

`define SMR_CAUSE_PIN      0
`define SMR_CAUSE_WDT      1
`define SMR_CAUSE_POC      2
`define SMR_CAUSE_LSD      3

`define SMR_RESET_VECTOR   16'h0000
`define SMR_WAIT_VECTOR    5'h09
`define SMR_WAIT_NEXT      5'h03
`define SMR_CLK_MHZ        40
`define SMR_FAST_SETTLE_NS 361000
`define SMR_FAST_SETTLE_CYC ((`SMR_FAST_SETTLE_NS * `SMR_CLK_MHZ) / 1000)

`endif

// ==== rtl/smr_ctrl.sv ====
// Purpose : Stop-mode entry/release and reset sequencing
// Assumes : All inputs synchronous to sys_clk; one interrupt source presented at a time
// Notes   : Register port answers in the cycle after a read strobe
//
// The plain strobed port and the address map were chosen for this implementation.
`include "smr_cfg.svh"

module smr_ctrl #(
   parameter int FAST_SETTLE_CYC = `SMR_FAST_SETTLE_CYC,
   parameter int XTAL_SETTLE_BASE = 256,
   parameter int RST_SETTLE_CYC  = 64
) (
   // Clock and reset
   input  wire logic               sys_clk,
   input  wire logic               rstn,
   // Register port
   input  wire logic [3:0]         reg_addr,
   input  wire logic [15:0]        reg_wdata,
   input  wire logic               reg_wr,
   input  wire logic               reg_rd,
   output logic      [15:0]        reg_rdata,
   // CPU core
   input  wire logic               stop_exec,
   input  wire logic               cpu_on_main_clk,
   input  wire logic               cpu_on_fast_osc,
   output logic                    cpu_clk_en,
   output logic                    vector_service,
   output logic                    resume_next,
   output logic                    reset_start,
   output logic      [15:0]        start_vector_addr,
   output logic                    core_reset_n,
   output logic                    low_supply_reset_n,
   output logic                    pins_hiz,
   output smr_pkg::smr_state_t     seq_state,
   // Interrupt controller
   input  wire logic               interrupt_request_flag,
   input  wire logic               interrupt_mask_flag,
   input  wire logic               interrupt_priority_flag,
   input  wire logic               global_interrupt_enable_flag,
   input  wire logic               in_service_priority_flag,
   // Reset sources
   input  wire logic               reset_pin_n,
   input  wire logic               wdt_overflow,
   input  wire logic               power_on_clear_detector,
   input  wire logic               low_supply_detector,
   // Oscillator and peripheral clock gates
   output logic                    main_osc_en,
   output logic                    fast_osc_en,
   output logic                    sub_osc_en,
   output logic                    slow_osc_en,
   output logic                    ext_clk_accept,
   output logic                    wdt_clk_en,
   output logic                    rtc_clk_en,
   output logic                    lcd_clk_en,
   output logic                    serial_clk_en
);
   import smr_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////////////////
   smr_regs_t r;
   smr_regs_t next_r;

   logic       unmasked;
   logic       service;
   logic       pin_rst;
   logic       poc_rst;
   logic       lsd_rst;
   logic       any_rst;
   logic [3:0] new_cause;
   logic [15:0] xtal_cnt;
   logic [15:0] settle_cnt;

   // Detector levels: high means supply at or above threshold
   assign pin_rst   = !reset_pin_n;
   assign poc_rst   = !power_on_clear_detector;
   assign lsd_rst   = !low_supply_detector && r.ctrl[`SMR_CTRL_LSD_EN];
   assign any_rst   = pin_rst || wdt_overflow || poc_rst || lsd_rst;
   assign new_cause = {lsd_rst, poc_rst, wdt_overflow, pin_rst};

   assign unmasked = interrupt_request_flag && !interrupt_mask_flag;
   // Priority 1 needs both enable and in-service flags
   assign service  = interrupt_priority_flag ?
                     (global_interrupt_enable_flag && in_service_priority_flag) :
                     global_interrupt_enable_flag;

   // Crystal settle doubles per select step
   assign xtal_cnt   = 16'(XTAL_SETTLE_BASE) << r.ctrl[`SMR_CTRL_SEL_LO +: 3];
   assign settle_cnt = cpu_on_fast_osc ? 16'(FAST_SETTLE_CYC) : xtal_cnt;

   ////////////////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_r = r;
      next_r.rdata = 16'h0000;
      // Sticky cause bits: a new reset wins over a software clear
      if (reg_wr && reg_addr == `SMR_ADDR_CAUSE) begin
         next_r.cause = r.cause & ~reg_wdata[3:0];
      end
      next_r.cause = next_r.cause | new_cause;
      if (reg_wr && reg_addr == `SMR_ADDR_CTRL && r.st == SMR_RUN) begin
         next_r.ctrl = reg_wdata;
      end
      if (reg_rd) begin
         case (reg_addr)
            `SMR_ADDR_CTRL:   next_r.rdata = r.ctrl;
            `SMR_ADDR_STATUS: next_r.rdata = {8'h00, 1'b0, r.settled, r.st};
            `SMR_ADDR_CAUSE:  next_r.rdata = {12'h000, r.cause};
            default:          next_r.rdata = 16'h0000;
         endcase
      end

      if (any_rst) begin
         // Reset takes precedence in every state, stop included
         if (r.st != SMR_RESET) begin
            next_r.from_stop = (r.st == SMR_STOP);
            next_r.lsd_only  = 1'b1;
         end
         next_r.lsd_only = next_r.lsd_only && !(pin_rst || wdt_overflow || poc_rst);
         next_r.st       = SMR_RESET;
         next_r.settled  = 1'b0;
      end else begin
         case (r.st)
            SMR_RUN: begin
               if (stop_exec && cpu_on_main_clk) begin
                  next_r.settled = 1'b0;
                  if (unmasked) begin
                     // Falls back to halt: clocks keep running through the settle
                     next_r.st   = SMR_SETTLE;
                     next_r.cnt  = xtal_cnt;
                     next_r.vect = service;
                  end else begin
                     next_r.st = SMR_STOP;
                  end
               end
            end
            SMR_STOP: begin
               if (unmasked) begin
                  next_r.st   = SMR_SETTLE;
                  next_r.cnt  = settle_cnt;
                  next_r.vect = service;
               end
            end
            SMR_SETTLE: begin
               if (r.cnt <= 16'h0001) begin
                  next_r.st      = SMR_WAIT;
                  next_r.settled = 1'b1;
                  next_r.wcnt    = r.vect ? `SMR_WAIT_VECTOR : `SMR_WAIT_NEXT;
               end else begin
                  next_r.cnt = r.cnt - 16'h0001;
               end
            end
            SMR_WAIT: begin
               if (r.wcnt <= 5'h01) begin
                  next_r.st = SMR_RUN;
               end else begin
                  next_r.wcnt = r.wcnt - 5'h01;
               end
            end
            SMR_RESET: begin
               // Sources gone: self-release for watchdog and detectors alike
               next_r.st  = SMR_RSETTLE;
               next_r.cnt = 16'(RST_SETTLE_CYC);
               next_r.from_stop = 1'b0;
               if (!r.lsd_only) begin
                  next_r.ctrl = `SMR_CTRL_RESET;
               end else begin
                  next_r.ctrl = `SMR_CTRL_RESET |
                                (r.ctrl & (16'h0001 << `SMR_CTRL_LSD_EN));
               end
            end
            SMR_RSETTLE: begin
               if (r.cnt <= 16'h0001) begin
                  next_r.st      = SMR_RUN;
                  next_r.settled = 1'b1;
               end else begin
                  next_r.cnt = r.cnt - 16'h0001;
               end
            end
            default: next_r.st = SMR_RESET;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         r <= '{st: SMR_RESET, cnt: 16'h0000, wcnt: 5'h00, vect: 1'b0, from_stop: 1'b0,
                lsd_only: 1'b0, settled: 1'b0, ctrl: `SMR_CTRL_RESET, cause: 4'h0,
                rdata: 16'h0000};
      end else begin
         r <= next_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   logic in_rst;
   logic stopped;

   assign in_rst  = (r.st == SMR_RESET);
   assign stopped = (r.st == SMR_STOP);

   assign reg_rdata         = r.rdata;
   assign seq_state         = r.st;
   assign cpu_clk_en        = (r.st == SMR_RUN) || (r.st == SMR_WAIT);
   assign vector_service    = (r.st == SMR_WAIT) && r.wcnt <= 5'h01 && r.vect && !any_rst;
   assign resume_next       = (r.st == SMR_WAIT) && r.wcnt <= 5'h01 && !r.vect && !any_rst;
   assign reset_start       = (r.st == SMR_RSETTLE) && r.cnt <= 16'h0001 && !any_rst;
   assign start_vector_addr = `SMR_RESET_VECTOR;
   // Contents of a stopped core survive while the reset input stands
   assign core_reset_n      = !((in_rst && !r.from_stop) || r.st == SMR_RSETTLE);
   assign low_supply_reset_n = !((in_rst && !r.lsd_only) || (r.st == SMR_RSETTLE && r.ctrl ==
                               `SMR_CTRL_RESET && !r.lsd_only));
   assign pins_hiz          = in_rst || (r.st == SMR_RSETTLE);
   assign main_osc_en       = !in_rst && !stopped;
   assign fast_osc_en       = !in_rst && !stopped;
   assign ext_clk_accept    = !in_rst && !stopped;
   assign sub_osc_en        = !in_rst && r.ctrl[`SMR_CTRL_SUB_RUN];
   // Stop leaves the slow oscillator as software last set it
   assign slow_osc_en       = !in_rst &&
                              (!r.ctrl[`SMR_CTRL_SW_STOP] || r.ctrl[`SMR_CTRL_SLOW_RUN]);
   assign wdt_clk_en        = slow_osc_en && !(stopped && r.ctrl[`SMR_CTRL_SW_STOP]);
   assign rtc_clk_en        = !in_rst && (!stopped ||
                              (r.ctrl[`SMR_CTRL_RTC_SUB] && r.ctrl[`SMR_CTRL_SUB_RUN]));
   assign lcd_clk_en        = !in_rst && (!stopped ||
                              (r.ctrl[`SMR_CTRL_LCD_SUB] && r.ctrl[`SMR_CTRL_SUB_RUN]));
   assign serial_clk_en     = !in_rst && (!stopped ||
                              (r.ctrl[`SMR_CTRL_SER_CNT] && r.ctrl[`SMR_CTRL_CNT_RUN]));

   ////////////////////////////////////////////////////////////////////////////////////////////
   sequence s_release_vect;
      (r.st == SMR_WAIT && r.wcnt == `SMR_WAIT_VECTOR && !any_rst) ##8 vector_service;
   endsequence

   sequence s_release_next;
      (r.st == SMR_WAIT && r.wcnt == `SMR_WAIT_NEXT && !any_rst) ##2 resume_next;
   endsequence

   property p_stop_main_only;
      @(posedge sys_clk) disable iff (!rstn)
      (r.st == SMR_RUN && stop_exec && !cpu_on_main_clk && !any_rst) |=> r.st == SMR_RUN;
   endproperty
   a_stop_main_only: assert property (p_stop_main_only) else $error("stop off main clock");

   property p_pending_cancels;
      @(posedge sys_clk) disable iff (!rstn)
      (r.st == SMR_RUN && stop_exec && cpu_on_main_clk && unmasked && !any_rst)
      |=> r.st == SMR_SETTLE && main_osc_en;
   endproperty
   a_pending_cancels: assert property (p_pending_cancels) else $error("pending irq stopped");

   property p_wait_vect;
      @(posedge sys_clk) disable iff (!rstn || any_rst)
      ($rose(r.st == SMR_WAIT) && r.vect) |-> s_release_vect;
   endproperty
   a_wait_vect: assert property (p_wait_vect) else $error("vector wait not nine");

   property p_wait_next;
      @(posedge sys_clk) disable iff (!rstn || any_rst)
      ($rose(r.st == SMR_WAIT) && !r.vect) |-> s_release_next;
   endproperty
   a_wait_next: assert property (p_wait_next) else $error("next wait not three");

   property p_mask_holds;
      @(posedge sys_clk) disable iff (!rstn)
      (stopped && interrupt_mask_flag && !any_rst) |=> stopped;
   endproperty
   a_mask_holds: assert property (p_mask_holds) else $error("masked irq left stop");

   property p_reset_first;
      @(posedge sys_clk) disable iff (!rstn)
      (stopped && any_rst && unmasked) |=> in_rst && pins_hiz;
   endproperty
   a_reset_first: assert property (p_reset_first) else $error("irq beat reset");

   property p_osc_off;
      @(posedge sys_clk) disable iff (!rstn)
      in_rst |-> !main_osc_en && !fast_osc_en && !sub_osc_en && !slow_osc_en && !ext_clk_accept;
   endproperty
   a_osc_off: assert property (p_osc_off) else $error("oscillator on in reset");

   property p_hiz_settle;
      @(posedge sys_clk) disable iff (!rstn)
      (in_rst && !any_rst) |=> pins_hiz && !cpu_clk_en;
   endproperty
   a_hiz_settle: assert property (p_hiz_settle) else $error("pins driven after reset");

   property p_stop_keeps;
      @(posedge sys_clk) disable iff (!rstn)
      (stopped && pin_rst) |=> core_reset_n && pins_hiz;
   endproperty
   a_stop_keeps: assert property (p_stop_keeps) else $error("stop contents lost");

   property p_lsd_spared;
      @(posedge sys_clk) disable iff (!rstn)
      (r.st == SMR_RUN && lsd_rst && !pin_rst && !wdt_overflow && !poc_rst) |=>
      low_supply_reset_n && r.ctrl[`SMR_CTRL_LSD_EN];
   endproperty
   a_lsd_spared: assert property (p_lsd_spared) else $error("low supply logic reset");

   property p_wdt_stop;
      @(posedge sys_clk) disable iff (!rstn)
      (stopped && r.ctrl[`SMR_CTRL_SW_STOP]) |-> !wdt_clk_en;
   endproperty
   a_wdt_stop: assert property (p_wdt_stop) else $error("watchdog clock in stop");

   property p_serial_stop;
      @(posedge sys_clk) disable iff (!rstn)
      (stopped && !r.ctrl[`SMR_CTRL_CNT_RUN]) |-> !serial_clk_en;
   endproperty
   a_serial_stop: assert property (p_serial_stop) else $error("serial runs in stop");

   property p_stop_enter;
      @(posedge sys_clk) disable iff (!rstn)
      (r.st == SMR_RUN && stop_exec && cpu_on_main_clk && !unmasked && !any_rst)
      |=> stopped && !cpu_clk_en && !main_osc_en;
   endproperty
   a_stop_enter: assert property (p_stop_enter) else $error("stop not entered");

   property p_irq_release;
      @(posedge sys_clk) disable iff (!rstn)
      (stopped && unmasked && !any_rst) |=> r.st == SMR_SETTLE && r.vect == $past(service);
   endproperty
   a_irq_release: assert property (p_irq_release) else $error("irq left stop badly");

   property p_fast_settle;
      @(posedge sys_clk) disable iff (!rstn)
      (stopped && unmasked && cpu_on_fast_osc && !any_rst) |=> r.cnt == 16'(FAST_SETTLE_CYC);
   endproperty
   a_fast_settle: assert property (p_fast_settle) else $error("fast settle count");

   property p_reset_enter;
      @(posedge sys_clk) disable iff (!rstn)
      any_rst |=> in_rst && pins_hiz;
   endproperty
   a_reset_enter: assert property (p_reset_enter) else $error("reset not entered");

   // Release hands over on the fast oscillator with the pins driven again
   property p_reset_exit;
      @(posedge sys_clk) disable iff (!rstn)
      (r.st == SMR_RSETTLE && r.cnt <= 16'h0001 && !any_rst) |->
      reset_start ##1 (r.st == SMR_RUN && !pins_hiz && core_reset_n && fast_osc_en);
   endproperty
   a_reset_exit: assert property (p_reset_exit) else $error("reset release wrong");

   property p_stop_kept;
      @(posedge sys_clk) disable iff (!rstn)
      (in_rst && r.from_stop) |-> core_reset_n && pins_hiz && !main_osc_en;
   endproperty
   a_stop_kept: assert property (p_stop_kept) else $error("stop contents reset");

   property p_slow_kept;
      @(posedge sys_clk) disable iff (!rstn)
      (r.st == SMR_RUN && stop_exec && cpu_on_main_clk && !any_rst) |=>
      slow_osc_en == $past(slow_osc_en);
   endproperty
   a_slow_kept: assert property (p_slow_kept) else $error("slow oscillator changed");

   property p_wdt_runs;
      @(posedge sys_clk) disable iff (!rstn)
      (stopped && !r.ctrl[`SMR_CTRL_SW_STOP]) |-> wdt_clk_en;
   endproperty
   a_wdt_runs: assert property (p_wdt_runs) else $error("watchdog halted in stop");

   property p_sub_only;
      @(posedge sys_clk) disable iff (!rstn)
      (stopped && !r.ctrl[`SMR_CTRL_RTC_SUB] && !r.ctrl[`SMR_CTRL_LCD_SUB]) |->
      !rtc_clk_en && !lcd_clk_en;
   endproperty
   a_sub_only: assert property (p_sub_only) else $error("counter runs in stop");

   property p_cause_set;
      @(posedge sys_clk) disable iff (!rstn)
      any_rst |=> (r.cause & $past(new_cause)) == $past(new_cause);
   endproperty
   a_cause_set: assert property (p_cause_set) else $error("reset cause lost");

endmodule

// ==== rtl/smr_pkg.sv ====
// Purpose : Types of the stop-mode and reset sequencer
// Assumes : One-hot state codes
// Notes   : State record is registered as a whole
package smr_pkg;
   typedef enum logic [5:0] {
      SMR_RUN     = 6'h01,
      SMR_STOP    = 6'h02,
      SMR_SETTLE  = 6'h04,
      SMR_WAIT    = 6'h08,
      SMR_RESET   = 6'h10,
      SMR_RSETTLE = 6'h20
   } smr_state_t;

   typedef struct packed {
      smr_state_t  st;
      logic [15:0] cnt;
      logic [4:0]  wcnt;
      logic        vect;
      logic        from_stop;
      logic        lsd_only;
      logic        settled;
      logic [15:0] ctrl;
      logic [3:0]  cause;
      logic [15:0] rdata;
   } smr_regs_t;
endpackage

// ==== tb/smr_cpu_model.sv ====
// Purpose : Behavioural CPU core and interrupt controller beside the sequencer
// Assumes : Bench commands change just after a rising edge
// Notes   : One interrupt source; its request flag clears only on acknowledge or clear
module smr_cpu_model (
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rstn,
   // Bench commands: stop, raise, clear; flags are mask, priority, enable, in-service
   input  wire logic [2:0] cmd,
   input  wire logic [3:0] flags,
   input  wire logic       on_main,
   input  wire logic       on_fast,
   // Sequencer side
   input  wire logic       cpu_clk_en,
   input  wire logic       vector_service,
   output logic            stop_exec,
   output logic            cpu_on_main_clk,
   output logic            cpu_on_fast_osc,
   output logic            interrupt_request_flag,
   output logic            interrupt_mask_flag,
   output logic            interrupt_priority_flag,
   output logic            global_interrupt_enable_flag,
   output logic            in_service_priority_flag
);
   timeunit 1ns;
   timeprecision 100ps;
   // A stalled core cannot execute anything, so stop only leaves a clocked core
   assign stop_exec = cmd[2] & cpu_clk_en;
   assign cpu_on_main_clk = on_main;
   assign cpu_on_fast_osc = on_fast;
   assign {interrupt_mask_flag, interrupt_priority_flag} = flags[3:2];
   assign {global_interrupt_enable_flag, in_service_priority_flag} = flags[1:0];

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn)
         interrupt_request_flag <= 1'h0;
      else if (cmd[1])
         interrupt_request_flag <= 1'h1;
      else if (cmd[0] || vector_service)
         interrupt_request_flag <= 1'h0;
   end
endmodule

// ==== tb/tb_stop_mode_and_reset_control.sv ====
// Purpose : Self-checking bench of the stop-mode and reset sequencer
// Assumes : Settle counts shortened by parameter
// Notes   : Release decision cases run from a table; resets by hand
`include "smr_cfg.svh"
module tb_stop_mode_and_reset_control;
   timeunit 1ns;
   timeprecision 100ps;
   import smr_pkg::*;
   localparam int FAST = 20;
   localparam int RST = 4;
   typedef struct packed {logic [3:0] fl; logic fast; logic [1:0] act;} smr_row_t;
   // act: 0 held then serviced, 1 vectored, 2 next instruction
   smr_row_t rows [6] = '{'{4'h0, 1'h0, 2'h2}, '{4'h2, 1'h1, 2'h1}, '{4'h5, 1'h0, 2'h2},
                          '{4'h6, 1'h0, 2'h2}, '{4'h7, 1'h1, 2'h1}, '{4'h8, 1'h0, 2'h0}};
   logic        sys_clk = 1'h0, rstn = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
   logic        on_main = 1'h1, on_fast = 1'h0;
   logic [2:0]  cmd = 3'h0;
   logic [3:0]  reg_addr = 4'h0, flags = 4'h0, src = 4'h0;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata, start_vector_addr;
   logic        stop_exec, cpu_on_main_clk, cpu_on_fast_osc, cpu_clk_en, vector_service;
   logic        resume_next, reset_start, core_reset_n, low_supply_reset_n, pins_hiz;
   logic        interrupt_request_flag, interrupt_mask_flag, interrupt_priority_flag;
   logic        global_interrupt_enable_flag, in_service_priority_flag;
   logic        main_osc_en, fast_osc_en, sub_osc_en, slow_osc_en, ext_clk_accept;
   logic        wdt_clk_en, rtc_clk_en, lcd_clk_en, serial_clk_en;
   smr_state_t  seq_state;
   int          mismatches = 0, tests_run = 0;
   // Reset sources: pin, watchdog, power-on-clear, low supply
   wire logic reset_pin_n = ~src[0];
   wire logic wdt_overflow = src[1];
   wire logic power_on_clear_detector = ~src[2];
   wire logic low_supply_detector = ~src[3];

   always #12.5 sys_clk = ~sys_clk;

   smr_ctrl #(.FAST_SETTLE_CYC(FAST), .XTAL_SETTLE_BASE(4), .RST_SETTLE_CYC(RST)) uut (
      .sys_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .stop_exec,
      .cpu_on_main_clk, .cpu_on_fast_osc, .cpu_clk_en, .vector_service, .resume_next,
      .reset_start, .start_vector_addr, .core_reset_n, .low_supply_reset_n, .pins_hiz,
      .seq_state, .interrupt_request_flag, .interrupt_mask_flag, .interrupt_priority_flag,
      .global_interrupt_enable_flag, .in_service_priority_flag, .reset_pin_n, .wdt_overflow,
      .power_on_clear_detector, .low_supply_detector, .main_osc_en, .fast_osc_en,
      .sub_osc_en, .slow_osc_en, .ext_clk_accept, .wdt_clk_en, .rtc_clk_en, .lcd_clk_en,
      .serial_clk_en);

   smr_cpu_model cpu (
      .sys_clk, .rstn, .cmd, .flags, .on_main, .on_fast, .cpu_clk_en, .vector_service,
      .stop_exec, .cpu_on_main_clk, .cpu_on_fast_osc, .interrupt_request_flag,
      .interrupt_mask_flag, .interrupt_priority_flag, .global_interrupt_enable_flag,
      .in_service_priority_flag);

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge sys_clk);
      reg_wr <= 1'h0;
   endtask

   // Read data must stand for exactly the one cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge sys_clk);
      reg_rd <= 1'h0;
      #1 check(reg_rdata, exp);
      @(posedge sys_clk);
      #1 check(reg_rdata, 16'h0000);
   endtask

   task automatic pulse(input logic [2:0] c);
      @(posedge sys_clk);
      cmd <= c;
      @(posedge sys_clk);
      cmd <= 3'h0;
      #1;
   endtask

   task automatic release_chk(input int es, input logic ev);
      int ns = 0;
      int nw = 0;
      for (int k = 0; k < 200; k++) begin
         @(posedge sys_clk);
         #1;
         if (seq_state === SMR_SETTLE) ns++;
         if (seq_state === SMR_WAIT) nw++;
         if (vector_service === 1'h1 || resume_next === 1'h1) break;
      end
      check(ns, es);
      check(nw, ev ? 9 : 3);
      check({vector_service, resume_next}, {ev, ~ev});
   endtask

   task automatic rst_tail();
      int n = 0;
      for (int k = 0; k < 100 && reset_start !== 1'h1; k++) begin
         @(posedge sys_clk);
         #1;
         if (seq_state === SMR_RSETTLE && pins_hiz === 1'h1) n++;
      end
      check(n, RST);
      check(start_vector_addr, 16'h0000);
   endtask

   task automatic rst_src(input int i, input logic [15:0] ctl);
      wr(`SMR_ADDR_CTRL, 16'h00C2);
      @(posedge sys_clk);
      src <= 4'h1 << i;
      repeat (3) @(posedge sys_clk);
      #1 check(seq_state, SMR_RESET);
      check({pins_hiz, core_reset_n, cpu_clk_en, main_osc_en, fast_osc_en, sub_osc_en,
             slow_osc_en, ext_clk_accept}, 8'h80);
      check(low_supply_reset_n, 16'(i == 3));
      src <= 4'h0;
      rst_tail();
      rd(`SMR_ADDR_CAUSE, 16'h0001 << i);
      wr(`SMR_ADDR_CAUSE, 16'h000F);
      rd(`SMR_ADDR_CTRL, ctl);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge sys_clk);
      mismatches++;
      final_report();
   end

   initial begin
      repeat (2) @(posedge sys_clk);
      #1 check(seq_state, SMR_RESET);
      rstn <= 1'h1;
      rst_tail();
      wr(`SMR_ADDR_CAUSE, 16'h000F);
      rd(`SMR_ADDR_CTRL, 16'h0042);
      rd(4'hC, 16'h0000);
      wr(4'hC, 16'hFFFF);
      rd(`SMR_ADDR_CTRL, 16'h0042);
      foreach (rows[i]) begin
         flags <= rows[i].fl;
         on_fast <= rows[i].fast;
         pulse(3'h4);
         check(seq_state, SMR_STOP);
         pulse(3'h2);
         if (rows[i].act == 2'h0) begin
            repeat (20) @(posedge sys_clk);
            #1 check(seq_state, SMR_STOP);
            flags <= 4'h2;
         end
         release_chk(rows[i].fast ? FAST : 4, rows[i].act != 2'h2);
         pulse(3'h1);
      end
      // Pending request at the stop falls back through settling
      flags <= 4'h0;
      on_fast <= 1'h0;
      pulse(3'h2);
      pulse(3'h4);
      check(seq_state, SMR_SETTLE);
      release_chk(3, 1'h0);
      pulse(3'h1);
      rd(`SMR_ADDR_STATUS, 16'h0041);
      on_main <= 1'h0;
      pulse(3'h4);
      check(seq_state, SMR_RUN);
      on_main <= 1'h1;
      wr(`SMR_ADDR_CTRL, 16'h0077);
      pulse(3'h4);
      check({wdt_clk_en, slow_osc_en, rtc_clk_en, lcd_clk_en, serial_clk_en}, 5'h0D);
      pulse(3'h2);
      release_chk(4, 1'h0);
      check({lcd_clk_en, main_osc_en, fast_osc_en, ext_clk_accept}, 4'hF);
      pulse(3'h1);
      wr(`SMR_ADDR_CTRL, 16'h004E);
      pulse(3'h4);
      check({wdt_clk_en, slow_osc_en, rtc_clk_en, lcd_clk_en, serial_clk_en}, 5'h1E);
      // Reset and interrupt together while stopped: both reach the sequencer at one edge
      @(posedge sys_clk);
      cmd <= 3'h2;
      @(posedge sys_clk);
      cmd <= 3'h0;
      src <= 4'h1;
      repeat (2) @(posedge sys_clk);
      #1 check({seq_state, core_reset_n, pins_hiz}, {SMR_RESET, 2'h3});
      src <= 4'h0;
      rst_tail();
      pulse(3'h1);
      for (int i = 0; i < 4; i++) rst_src(i, (i == 3) ? 16'h00C2 : 16'h0042);
      final_report();
   end
endmodule
